//--- core/csia_core_sfr.sv
// core special-function register slice with the first indirect channel
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module csia_core_sfr (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  csia_pkg::csia_bus_t     bus,
  input  wire logic [7:0]         wreg,
  input  csia_pkg::csia_evt_t     evt,
  output logic      [7:0]         rd_data,
  output csia_pkg::csia_core_t    core_regs
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0]            stack_top_upper_r;
  logic [7:0]            stack_top_high_r;
  logic [7:0]            stack_top_low_r;
  logic [7:0]            stack_pointer_status_r;
  logic [7:0]            pc_upper_holding_r;
  logic [7:0]            pc_high_holding_r;
  logic [7:0]            pc_low_byte_r;
  logic [7:0]            table_pointer_upper_r;
  logic [7:0]            table_pointer_high_r;
  logic [7:0]            table_pointer_low_r;
  logic [7:0]            table_latch_r;
  logic [7:0]            product_high_r;
  logic [7:0]            product_low_r;
  logic [7:0]            irq_control_main_r;
  logic [7:0]            irq_control_edges_r;
  logic [7:0]            irq_control_external_r;
  logic [11:0]           first_indirect_pointer_r;
  logic [7:0]            rdata_r;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  csia_pkg::csia_ind_t   ind_mode;
  logic [11:0]           ind_ea;
  logic [11:0]           ptr_nxt;
  logic [11:0]           tgt_addr;
  logic                  access;
  logic                  blocked;
  logic                  wr_en;
  logic                  rd_en;
  logic                  tgt_in_ram;
  logic [7:0]            ram_rdata;

  // true for any of the five virtual port addresses
  function automatic logic is_ind_port(input logic [11:0] a);
    is_ind_port = (a == csia_pkg::OFS_INDIRECT_PLAIN_PORT)   ||
                  (a == csia_pkg::OFS_INDIRECT_POSTINC_PORT) ||
                  (a == csia_pkg::OFS_INDIRECT_POSTDEC_PORT) ||
                  (a == csia_pkg::OFS_INDIRECT_PREINC_PORT)  ||
                  (a == csia_pkg::OFS_INDIRECT_OFFSET_PORT);
  endfunction

  // write hit on one register of this slice
  function automatic logic wr_hit(input logic en, input logic [11:0] a,
                                  input logic [11:0] ofs);
    wr_hit = en && (a == ofs);
  endfunction

  assign access = bus.we | bus.re;

  // which virtual port, if any, the bus address names
  always_comb
  begin
    ind_mode = csia_pkg::CSIA_IND_NONE;
    if (access)
    begin
      case (bus.addr)
        csia_pkg::OFS_INDIRECT_PLAIN_PORT:   ind_mode = csia_pkg::CSIA_IND_PLAIN;
        csia_pkg::OFS_INDIRECT_POSTINC_PORT: ind_mode = csia_pkg::CSIA_IND_POSTINC;
        csia_pkg::OFS_INDIRECT_POSTDEC_PORT: ind_mode = csia_pkg::CSIA_IND_POSTDEC;
        csia_pkg::OFS_INDIRECT_PREINC_PORT:  ind_mode = csia_pkg::CSIA_IND_PREINC;
        csia_pkg::OFS_INDIRECT_OFFSET_PORT:  ind_mode = csia_pkg::CSIA_IND_OFFSET;
        default:                             ind_mode = csia_pkg::CSIA_IND_NONE;
      endcase
    end
  end

  // pointer arithmetic lives in its own combinational unit
  csia_ptr_step u_ptr_step (
    .ptr     (first_indirect_pointer_r),
    .mode    (ind_mode),
    .woff    (wreg),
    .ea      (ind_ea),
    .ptr_nxt (ptr_nxt)
  );

  // indirect accesses are redirected, the port itself holds nothing
  assign tgt_addr = (ind_mode != csia_pkg::CSIA_IND_NONE) ? ind_ea : bus.addr;

  // a pointer aimed at a port again would recurse; it reads zero and writes nothing
  assign blocked    = (ind_mode != csia_pkg::CSIA_IND_NONE) && is_ind_port(ind_ea);
  assign wr_en      = bus.we & ~blocked;
  assign rd_en      = bus.re & ~blocked;
  assign tgt_in_ram = (tgt_addr < csia_pkg::SFR_BASE);

  // ----------------------------------------------------------------
  // data memory
  // ----------------------------------------------------------------
  csia_dram #(
    .AW (csia_pkg::DATA_ADDR_W),
    .DW (csia_pkg::DATA_W)
  ) u_dram (
    .clk_sys (clk_sys),
    .we      (wr_en & tgt_in_ram),
    .addr    (tgt_addr),
    .wdata   (bus.wdata),
    .rdata   (ram_rdata)
  );

  // read mux over this slice; every other special-function address is zero
  function automatic logic [7:0] sfr_value(input logic [11:0] a);
    case (a)
      csia_pkg::OFS_STACK_TOP_UPPER:       sfr_value = stack_top_upper_r;
      csia_pkg::OFS_STACK_TOP_HIGH:        sfr_value = stack_top_high_r;
      csia_pkg::OFS_STACK_TOP_LOW:         sfr_value = stack_top_low_r;
      csia_pkg::OFS_STACK_POINTER_STATUS:  sfr_value = stack_pointer_status_r;
      csia_pkg::OFS_PC_UPPER_HOLDING:      sfr_value = pc_upper_holding_r;
      csia_pkg::OFS_PC_HIGH_HOLDING:       sfr_value = pc_high_holding_r;
      csia_pkg::OFS_PC_LOW_BYTE:           sfr_value = pc_low_byte_r;
      csia_pkg::OFS_TABLE_POINTER_UPPER:   sfr_value = table_pointer_upper_r;
      csia_pkg::OFS_TABLE_POINTER_HIGH:    sfr_value = table_pointer_high_r;
      csia_pkg::OFS_TABLE_POINTER_LOW:     sfr_value = table_pointer_low_r;
      csia_pkg::OFS_TABLE_LATCH:           sfr_value = table_latch_r;
      csia_pkg::OFS_PRODUCT_HIGH:          sfr_value = product_high_r;
      csia_pkg::OFS_PRODUCT_LOW:           sfr_value = product_low_r;
      csia_pkg::OFS_IRQ_CONTROL_MAIN:      sfr_value = irq_control_main_r;
      csia_pkg::OFS_IRQ_CONTROL_EDGES:     sfr_value = irq_control_edges_r;
      csia_pkg::OFS_IRQ_CONTROL_EXTERNAL:  sfr_value = irq_control_external_r;
      csia_pkg::OFS_INDIRECT_POINTER_HIGH: sfr_value = {4'h0, first_indirect_pointer_r[11:8]};
      csia_pkg::OFS_FIRST_POINTER_LOW:     sfr_value = first_indirect_pointer_r[7:0];
      default:                             sfr_value = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // read data, valid only in the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdata_r <= csia_pkg::RST_ZERO;
    end
    else if (rd_en && tgt_in_ram)
    begin
      rdata_r <= ram_rdata;
    end
    else if (rd_en)
    begin
      rdata_r <= sfr_value(tgt_addr);
    end
    else
    begin
      rdata_r <= csia_pkg::RST_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // first indirect pointer
  // ----------------------------------------------------------------
  // a data write that lands on the pointer itself beats the auto step
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      first_indirect_pointer_r <= 12'h000;
    end
    else if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_FIRST_POINTER_LOW))
    begin
      first_indirect_pointer_r[7:0] <= bus.wdata;
    end
    else if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_INDIRECT_POINTER_HIGH))
    begin
      first_indirect_pointer_r[11:8] <= bus.wdata[3:0];
    end
    else if (ind_mode != csia_pkg::CSIA_IND_NONE)
    begin
      first_indirect_pointer_r <= ptr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // return-stack top
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stack_top_upper_r <= csia_pkg::RST_ZERO;
      stack_top_high_r  <= csia_pkg::RST_ZERO;
      stack_top_low_r   <= csia_pkg::RST_ZERO;
    end
    else
    begin
      if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_STACK_TOP_UPPER))
      begin
        stack_top_upper_r <= bus.wdata & csia_pkg::MASK_STACK_TOP_UPPER;
      end
      if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_STACK_TOP_HIGH))
      begin
        stack_top_high_r <= bus.wdata;
      end
      if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_STACK_TOP_LOW))
      begin
        stack_top_low_r <= bus.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // stack pointer and overflow flags
  // ----------------------------------------------------------------
  // overflow flags can only be cleared by software; a set in the same cycle wins
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stack_pointer_status_r <= csia_pkg::RST_ZERO;
    end
    else
    begin
      stack_pointer_status_r <= stack_pointer_status_nxt(stack_pointer_status_r);
    end
  end

  function automatic logic [7:0] stack_pointer_status_nxt(input logic [7:0] cur);
    logic [7:0] v;
    v = cur;
    if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_STACK_POINTER_STATUS))
    begin
      v = ((bus.wdata & ~csia_pkg::MASK_STACK_OVF_BITS) |
           (bus.wdata & cur & csia_pkg::MASK_STACK_OVF_BITS)) &
          csia_pkg::MASK_STACK_POINTER_STATUS;
    end
    v[csia_pkg::STK_FULL_BIT] = v[csia_pkg::STK_FULL_BIT] | evt.stk_full_set;
    v[csia_pkg::STK_UNF_BIT]  = v[csia_pkg::STK_UNF_BIT] | evt.stk_unf_set;
    stack_pointer_status_nxt = v;
  endfunction

  // ----------------------------------------------------------------
  // program counter latches
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pc_upper_holding_r <= csia_pkg::RST_ZERO;
      pc_high_holding_r  <= csia_pkg::RST_ZERO;
      pc_low_byte_r      <= csia_pkg::RST_ZERO;
    end
    else
    begin
      if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_PC_UPPER_HOLDING))
      begin
        pc_upper_holding_r <= bus.wdata & csia_pkg::MASK_PC_UPPER_HOLDING;
      end
      if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_PC_HIGH_HOLDING))
      begin
        pc_high_holding_r <= bus.wdata;
      end
      if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_PC_LOW_BYTE))
      begin
        pc_low_byte_r <= bus.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // table pointer and latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      table_pointer_upper_r <= csia_pkg::RST_ZERO;
      table_pointer_high_r  <= csia_pkg::RST_ZERO;
      table_pointer_low_r   <= csia_pkg::RST_ZERO;
    end
    else
    begin
      if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_TABLE_POINTER_UPPER))
      begin
        table_pointer_upper_r <= bus.wdata & csia_pkg::MASK_TABLE_POINTER_UPPER;
      end
      if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_TABLE_POINTER_HIGH))
      begin
        table_pointer_high_r <= bus.wdata;
      end
      if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_TABLE_POINTER_LOW))
      begin
        table_pointer_low_r <= bus.wdata;
      end
    end
  end

  // a table read result from the core beats a software write
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      table_latch_r <= csia_pkg::RST_ZERO;
    end
    else if (evt.table_latch_load)
    begin
      table_latch_r <= evt.table_latch_value;
    end
    else if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_TABLE_LATCH))
    begin
      table_latch_r <= bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // multiply product
  // ----------------------------------------------------------------
  // power-up value is undefined on the part; zero keeps simulation clean
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      product_high_r <= csia_pkg::RST_ZERO;
      product_low_r  <= csia_pkg::RST_ZERO;
    end
    else if (evt.prod_load)
    begin
      product_high_r <= evt.prod_value[15:8];
      product_low_r  <= evt.prod_value[7:0];
    end
    else
    begin
      if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_PRODUCT_HIGH))
      begin
        product_high_r <= bus.wdata;
      end
      if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_PRODUCT_LOW))
      begin
        product_low_r <= bus.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt control
  // ----------------------------------------------------------------
  // flag bits: hardware set ors in after the write, so a set is never lost
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irq_control_main_r <= csia_pkg::RST_ZERO;
    end
    else if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_IRQ_CONTROL_MAIN))
    begin
      irq_control_main_r <= bus.wdata |
                            ({5'h00, evt.main_flag_set} & csia_pkg::MASK_IRQ_FLAGS);
    end
    else
    begin
      irq_control_main_r <= irq_control_main_r |
                            ({5'h00, evt.main_flag_set} & csia_pkg::MASK_IRQ_FLAGS);
    end
  end

  // edge selects and priorities, plain storage
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irq_control_edges_r <= csia_pkg::RST_IRQ_CONTROL_EDGES;
    end
    else if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_IRQ_CONTROL_EDGES))
    begin
      irq_control_edges_r <= bus.wdata;
    end
  end

  // external line enables and flags
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irq_control_external_r <= csia_pkg::RST_IRQ_CONTROL_EXTERNAL;
    end
    else if (wr_hit(wr_en, tgt_addr, csia_pkg::OFS_IRQ_CONTROL_EXTERNAL))
    begin
      irq_control_external_r <= bus.wdata |
                                ({5'h00, evt.ext_flag_set} & csia_pkg::MASK_IRQ_FLAGS);
    end
    else
    begin
      irq_control_external_r <= irq_control_external_r |
                                ({5'h00, evt.ext_flag_set} & csia_pkg::MASK_IRQ_FLAGS);
    end
  end

  // ----------------------------------------------------------------
  // outputs, all taken straight from the registers above
  // ----------------------------------------------------------------
  assign rd_data = rdata_r;

  assign core_regs.tos     = {stack_top_upper_r[4:0], stack_top_high_r, stack_top_low_r};
  assign core_regs.stack_pointer_status  = stack_pointer_status_r;
  assign core_regs.pc_upper_holding  = pc_upper_holding_r[4:0];
  assign core_regs.pc_high_holding  = pc_high_holding_r;
  assign core_regs.pc_low_byte     = pc_low_byte_r;
  assign core_regs.tblptr  = {table_pointer_upper_r[5:0], table_pointer_high_r,
                              table_pointer_low_r};
  assign core_regs.table_latch  = table_latch_r;
  assign core_regs.prod    = {product_high_r, product_low_r};
  assign core_regs.irq_control_main  = irq_control_main_r;
  assign core_regs.irq_control_edges = irq_control_edges_r;
  assign core_regs.irq_control_external = irq_control_external_r;
  assign core_regs.ind_ptr = first_indirect_pointer_r;

endmodule

//--- core/csia_dram.sv
// data memory array behind the pointer and the direct low area
`timescale 1ns/1ps
module csia_dram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input  wire logic          clk_sys,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  // no reset on the array, content is undefined after power-up
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ----------------------------------------------------------------
  // write port, synchronous
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
  end

  // read is combinational; the caller registers it
  assign rdata = mem[addr];

endmodule

//--- core/csia_pkg.sv
// constants and carrier types for the core register slice
package csia_pkg;

  // ----------------------------------------------------------------
  // data space geometry
  // ----------------------------------------------------------------
  localparam int unsigned DATA_ADDR_W = 12;
  localparam int unsigned DATA_W      = 8;
  localparam logic [11:0] SFR_BASE    = 12'hf60;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_STACK_TOP_UPPER       = 12'hfff;
  localparam logic [11:0] OFS_STACK_TOP_HIGH        = 12'hffe;
  localparam logic [11:0] OFS_STACK_TOP_LOW         = 12'hffd;
  localparam logic [11:0] OFS_STACK_POINTER_STATUS  = 12'hffc;
  localparam logic [11:0] OFS_PC_UPPER_HOLDING      = 12'hffb;
  localparam logic [11:0] OFS_PC_HIGH_HOLDING       = 12'hffa;
  localparam logic [11:0] OFS_PC_LOW_BYTE           = 12'hff9;
  localparam logic [11:0] OFS_TABLE_POINTER_UPPER   = 12'hff8;
  localparam logic [11:0] OFS_TABLE_POINTER_HIGH    = 12'hff7;
  localparam logic [11:0] OFS_TABLE_POINTER_LOW     = 12'hff6;
  localparam logic [11:0] OFS_TABLE_LATCH           = 12'hff5;
  localparam logic [11:0] OFS_PRODUCT_HIGH          = 12'hff4;
  localparam logic [11:0] OFS_PRODUCT_LOW           = 12'hff3;
  localparam logic [11:0] OFS_IRQ_CONTROL_MAIN      = 12'hff2;
  localparam logic [11:0] OFS_IRQ_CONTROL_EDGES     = 12'hff1;
  localparam logic [11:0] OFS_IRQ_CONTROL_EXTERNAL  = 12'hff0;
  localparam logic [11:0] OFS_INDIRECT_PLAIN_PORT   = 12'hfef;
  localparam logic [11:0] OFS_INDIRECT_POSTINC_PORT = 12'hfee;
  localparam logic [11:0] OFS_INDIRECT_POSTDEC_PORT = 12'hfed;
  localparam logic [11:0] OFS_INDIRECT_PREINC_PORT  = 12'hfec;
  localparam logic [11:0] OFS_INDIRECT_OFFSET_PORT  = 12'hfeb;
  localparam logic [11:0] OFS_INDIRECT_POINTER_HIGH = 12'hfea;
  localparam logic [11:0] OFS_FIRST_POINTER_LOW     = 12'hfe9;

  // ----------------------------------------------------------------
  // reset values, implemented-bit masks, field positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_ZERO                  = 8'h00;
  localparam logic [7:0]  RST_IRQ_CONTROL_EDGES     = 8'hff;
  localparam logic [7:0]  RST_IRQ_CONTROL_EXTERNAL  = 8'hc0;
  localparam logic [7:0]  MASK_STACK_TOP_UPPER      = 8'h1f;
  localparam logic [7:0]  MASK_STACK_POINTER_STATUS = 8'hdf;
  localparam logic [7:0]  MASK_STACK_OVF_BITS       = 8'hc0;
  localparam logic [7:0]  MASK_PC_UPPER_HOLDING     = 8'h1f;
  localparam logic [7:0]  MASK_TABLE_POINTER_UPPER  = 8'h3f;
  localparam logic [7:0]  MASK_INDIRECT_POINTER_HI  = 8'h0f;
  localparam logic [7:0]  MASK_IRQ_FLAGS            = 8'h07;
  localparam int unsigned STK_FULL_BIT              = 7;
  localparam int unsigned STK_UNF_BIT               = 6;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSIA_IND_NONE    = 3'b000,
    CSIA_IND_PLAIN   = 3'b001,
    CSIA_IND_POSTINC = 3'b010,
    CSIA_IND_POSTDEC = 3'b011,
    CSIA_IND_PREINC  = 3'b100,
    CSIA_IND_OFFSET  = 3'b101
  } csia_ind_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } csia_bus_t;

  typedef struct packed {
    logic        stk_full_set;
    logic        stk_unf_set;
    logic [2:0]  main_flag_set;
    logic [2:0]  ext_flag_set;
    logic        prod_load;
    logic [15:0] prod_value;
    logic        table_latch_load;
    logic [7:0]  table_latch_value;
  } csia_evt_t;

  typedef struct packed {
    logic [20:0] tos;
    logic [7:0]  stack_pointer_status;
    logic [4:0]  pc_upper_holding;
    logic [7:0]  pc_high_holding;
    logic [7:0]  pc_low_byte;
    logic [21:0] tblptr;
    logic [7:0]  table_latch;
    logic [15:0] prod;
    logic [7:0]  irq_control_main;
    logic [7:0]  irq_control_edges;
    logic [7:0]  irq_control_external;
    logic [11:0] ind_ptr;
  } csia_core_t;

endpackage

//--- core/csia_ptr_step.sv
// effective address and next pointer value for one indirect access
`timescale 1ns/1ps
module csia_ptr_step (
  input  wire logic [11:0]        ptr,
  input  csia_pkg::csia_ind_t     mode,
  input  wire logic [7:0]         woff,
  output logic      [11:0]        ea,
  output logic      [11:0]        ptr_nxt
);

  // 12-bit wrap-around add of a signed step
  function automatic logic [11:0] add12(input logic [11:0] a, input logic [11:0] d);
    add12 = 12'(a + d);
  endfunction

  // address and pointer update per port kind
  always_comb
  begin
    ea      = ptr;
    ptr_nxt = ptr;
    case (mode)
      csia_pkg::CSIA_IND_PLAIN:   ptr_nxt = ptr;
      csia_pkg::CSIA_IND_POSTINC: ptr_nxt = add12(ptr, 12'h001);
      csia_pkg::CSIA_IND_POSTDEC: ptr_nxt = add12(ptr, 12'hfff);
      csia_pkg::CSIA_IND_PREINC:
      begin
        ptr_nxt = add12(ptr, 12'h001);
        ea      = add12(ptr, 12'h001);
      end
      csia_pkg::CSIA_IND_OFFSET:  ea = add12(ptr, {{4{woff[7]}}, woff});
      default:                    ptr_nxt = ptr;
    endcase
  end

endmodule

//--- dv/csia_core_sfr_monitor.sv
// port assertions for the core register slice
`timescale 1ns/1ps
module csia_core_sfr_monitor (
  input wire logic           clk_sys,
  input wire logic           rst,
  input csia_pkg::csia_bus_t bus,
  input wire logic [7:0]     wreg,
  input csia_pkg::csia_evt_t evt,
  input wire logic [7:0]     rd_data,
  input csia_pkg::csia_core_t core_regs
);
  // ---------------------------------------------
  // pointer and read-data relations
  // ---------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [11:0] p;
  // pointer in data ram only, so no write can hit it
  assign p = core_regs.ind_ptr;
  sequence s_port(a);
    (bus.re || bus.we) && bus.addr == a && p < 12'hf60;
  endsequence
  a_plain_ptr_kept: assert property (s_port(12'hfef) |=> $stable(p))
    else $error("plain port moved pointer");
  a_postinc_step: assert property (s_port(12'hfee) |=> p == $past(p) + 12'h001)
    else $error("post-increment step wrong");
  a_postdec_step: assert property (s_port(12'hfed) |=> p == $past(p) - 12'h001)
    else $error("post-decrement step wrong");
  a_preinc_step: assert property (s_port(12'hfec) |=> p == $past(p) + 12'h001)
    else $error("pre-increment step wrong");
  a_port_no_store: assert property (s_port(12'hfef) ##0 (bus.we && evt == '0)
    |=> core_regs == $past(core_regs)) else $error("port write changed a register");
  a_unimpl_reads_zero: assert property (bus.re && bus.addr inside {[12'hf60:12'hfe8]}
    |=> rd_data == 8'h00) else $error("unimplemented read not zero");
  a_ptr_low_load: assert property (bus.we && bus.addr == 12'hfe9
    |=> p[7:0] == $past(bus.wdata)) else $error("pointer low byte not loaded");
  a_ptr_high_load: assert property (bus.we && bus.addr == 12'hfea
    |=> p[11:8] == $past(bus.wdata[3:0])) else $error("pointer high nibble not loaded");
  a_idle_read_zero: assert property (!bus.re |=> rd_data == 8'h00)
    else $error("read data outside read slot");
endmodule
bind csia_core_sfr csia_core_sfr_monitor mon (.clk_sys(clk_sys), .rst(rst), .bus(bus),
  .wreg(wreg), .evt(evt), .rd_data(rd_data), .core_regs(core_regs));

//--- dv/tb_top.sv
// self-checking bench for the core register slice
`timescale 1ns/1ps
module tb_top;
  logic                 clk_sys, rst, w;
  csia_pkg::csia_bus_t  bus;
  csia_pkg::csia_evt_t  evt;
  csia_pkg::csia_core_t core_regs;
  logic [7:0]           wreg, rd_data, d, o;
  logic [11:0]          p, ea, base;
  logic [7:0]           m [logic [11:0]];
  logic [11:0]          cs [3] = '{12'h0ff, 12'h000, 12'h2ff};
  int                   fail_count, n_checks, cyc, k, op;
  csia_core_sfr uut (.clk_sys(clk_sys), .rst(rst), .bus(bus), .wreg(wreg), .evt(evt),
    .rd_data(rd_data), .core_regs(core_regs));
  // ---------------------------------------------
  // clock, tasks and model
  // ---------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task chk(string nm, logic [11:0] s, logic [11:0] e);
    n_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one strobe cycle; read data is valid just after the return edge
  task acc(logic [11:0] a, logic [7:0] dv, logic wr);
    @(posedge clk_sys);
    bus <= '{a, dv, wr, !wr};
    o = 8'($urandom);
    wreg <= o;
    @(posedge clk_sys);
    bus <= '0;
    #1;
  endtask
  task setp(logic [11:0] v);
    acc(12'hfea, {4'($urandom), v[11:8]}, 1'b1);
    acc(12'hfe9, v[7:0], 1'b1);
    p = v;
  endtask
  // modes: 0 plain, 1 post-inc, 2 post-dec, 3 pre-inc
  function automatic logic [11:0] eff(int md);
    logic [11:0] e;
    if (md == 3) p = p + 12'h001;
    e = p;
    if (md == 1) p = p + 12'h001;
    if (md == 2) p = p - 12'h001;
    return e;
  endfunction
  task finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // cut a hang short well past the expected run length
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      finish_test();
    end
  end
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    bus = '0;
    wreg = 8'h00;
    evt = '0;
    rst = 1'b1;
    k = $urandom(91);
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    for (k = 'hfe9; k <= 'hfff; k++)
      if (k < 'hfeb || k > 'hfef)
      begin
        acc(12'(k), 8'h00, 1'b0);
        chk("reset", rd_data, k == 'hff1 ? 8'hff : k == 'hff0 ? 8'hc0 : 8'h00);
      end
    for (k = 0; k < 6; k++)
    begin
      ea = k < 2 ? 12'hf60 + 12'(k * 'h88) : 12'hf60 + 12'($urandom_range(136));
      acc(ea, 8'($urandom), 1'b1);
      acc(ea, 8'h00, 1'b0);
      chk("unimpl", rd_data, 12'h000);
    end
    base = 12'h100 + 12'($urandom_range(3072));
    for (k = -64; k < 64; k++)
    begin
      d = 8'($urandom);
      m[base + 12'(k)] = d;
      acc(base + 12'(k), d, 1'b1);
    end
    setp(base);
    chk("ptr load", core_regs.ind_ptr, base);
    repeat (50)
    begin
      op = $urandom_range(3);
      w = 1'($urandom);
      d = 8'($urandom);
      ea = eff(op);
      if (w)
        m[ea] = d;
      acc(12'hfef - 12'(op), d, w);
      if (!w)
        chk("ind read", rd_data, m[ea]);
      chk("ptr step", core_regs.ind_ptr, p);
      acc(ea, 8'h00, 1'b0);
      chk("ram", rd_data, m[ea]);
    end
    // offset port: pointer plus signed working value, pointer left alone
    d = 8'($urandom);
    acc(12'hfeb, d, 1'b1);
    ea = p + {{4{o[7]}}, o};
    chk("offset ptr", core_regs.ind_ptr, p);
    acc(ea, 8'h00, 1'b0);
    chk("offset write", rd_data, d);
    foreach (cs[i])
    begin
      setp(cs[i]);
      ea = eff(i + 1);
      d = 8'($urandom);
      acc(12'hfee - 12'(i), d, 1'b1);
      chk("carry", core_regs.ind_ptr, p);
      acc(ea, 8'h00, 1'b0);
      chk("port write", rd_data, d);
    end
    finish_test();
  end
endmodule
